//--- esb_consts.svh
`ifndef ESB_CONSTS_SVH
`define ESB_CONSTS_SVH
// register offsets
`define ESB_OFS_TX_SI_ALIGN 8'h42
`define ESB_OFS_TX_SI_NONALIGN 8'h43
`define ESB_OFS_TX_RALARM 8'h44
`define ESB_OFS_TX_SA4 8'h45
`define ESB_OFS_TX_SA5 8'h46
`define ESB_OFS_TX_SA6 8'h47
`define ESB_OFS_TX_SA7 8'h48
`define ESB_OFS_TX_SA8 8'h49
`define ESB_OFS_TX_CTRL 8'h4a
`define ESB_OFS_RX_SA6 8'h5d
`define ESB_OFS_RX_SA7 8'h5e
`define ESB_OFS_RX_SA8 8'h5f
// insertion control fields
`define ESB_CTRL_SA8 0
`define ESB_CTRL_SA4 4
`define ESB_CTRL_RA 5
`define ESB_CTRL_INTL_NONALIGN_INSERT_EN 6
`define ESB_CTRL_INTL_ALIGN_INSERT_EN 7
// reset value of all registers
`define ESB_REG_RESET 8'h00
// host service window per multiframe
`define ESB_SERVICE_MS 2
`endif

//--- esb_pkg.sv
package esb_pkg;
    typedef logic [7:0] esb_byte_t;
    // national spare bits of one odd frame, index 0 = sa4
    typedef logic [4:0] esb_spare_t;
endpackage

//--- esb_spare_bits.sv
// Behaviour
// RULE_01 - capture received sa6 of odd frames 1..15, frame 1 at bit 7
// RULE_02 - capture received sa7 of odd frames 1..15, frame 1 at bit 7
// RULE_03 - capture received sa8 of odd frames 1..15, frame 1 at bit 7
// RULE_04 - writable si byte for align frames 0..14, frame 0 at bit 7
// RULE_05 - writable si byte for non-align frames 1..15, frame 1 at bit 7
// RULE_06 - writable remote-alarm byte for odd frames, frame 1 at bit 7
// RULE_07 - five writable sa4..sa8 bytes for odd frames, frame 1 at bit 7
// RULE_08 - control bits 0..4 enable sa8..sa4 insertion from their bytes
// RULE_09 - control bit 5 enables remote-alarm byte insertion
// RULE_10 - control bit 6 enables non-align si byte insertion
// RULE_11 - control bit 7 enables align si byte insertion
// RULE_12 - all transmit bytes and control reset to zero
// RULE_13 - capture bytes refresh once per multiframe; host reads within 2ms
// RULE_14 - receive multiframe flag pulses at each multiframe boundary
// RULE_15 - transmit bytes sampled at transmit multiframe flag
// RULE_16 - msb of each byte is the first bit of the multiframe
// RULE_17 - disabled positions carry the framer default source value
`timescale 1ns/10ps
`include "esb_consts.svh"
module esb_spare_bits (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // control port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // receive frame timing, from the framer on this clock
    input wire logic rx_frame_strobe_in,
    input wire logic [3:0] rx_frame_num_in,
    input wire logic [4:0] rx_spare_in,
    output logic rx_multiframe_flag_out,
    // transmit frame timing, from the framer on this clock
    input wire logic tx_frame_strobe_in,
    input wire logic [3:0] tx_frame_num_in,
    input wire logic tx_si_dflt_in,
    input wire logic tx_ra_dflt_in,
    input wire logic [4:0] tx_spare_dflt_in,
    output logic tx_multiframe_flag_out,
    output logic tx_si_out,
    output logic tx_ra_out,
    output logic [4:0] tx_spare_out
);
    // ********************************
    // reset release
    // ********************************
    logic rst_meta_q;
    logic rst_n_q;
    // two stages so release is clean against the clock
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ********************************
    // helpers
    // ********************************
    // bit position of a frame in a byte: frame 0/1 -> 7, frame 14/15 -> 0
    function automatic logic [2:0] esb_pos(input logic [3:0] frame);
        esb_pos = 3'h7 - frame[3:1];
    endfunction

    // ********************************
    // register file
    // ********************************
    esb_pkg::esb_byte_t tx_intl_align_bits_q;
    esb_pkg::esb_byte_t tx_intl_nonalign_bits_q;
    esb_pkg::esb_byte_t tx_remote_alarm_bits_q;
    esb_pkg::esb_byte_t tx_spare_bits_q [5];
    esb_pkg::esb_byte_t tx_spare_insert_ctrl_q;
    esb_pkg::esb_byte_t rx_spare_bits_q [3];
    logic [7:0] tx_spare_idx;
    assign tx_spare_idx = reg_addr_in - `ESB_OFS_TX_SA4;

    // RULE_04 RULE_05 RULE_06 host writes
    // RULE_07 RULE_12 spare bytes, zero reset
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_intl_align_bits_q <= `ESB_REG_RESET;
            tx_intl_nonalign_bits_q <= `ESB_REG_RESET;
            tx_remote_alarm_bits_q <= `ESB_REG_RESET;
            tx_spare_insert_ctrl_q <= `ESB_REG_RESET;
            for (int i = 0; i < 5; i++) begin
                tx_spare_bits_q[i] <= `ESB_REG_RESET;
            end
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `ESB_OFS_TX_SI_ALIGN: tx_intl_align_bits_q <= reg_wdata_in;
                `ESB_OFS_TX_SI_NONALIGN: begin
                    tx_intl_nonalign_bits_q <= reg_wdata_in;
                end
                `ESB_OFS_TX_RALARM: tx_remote_alarm_bits_q <= reg_wdata_in;
                `ESB_OFS_TX_CTRL: tx_spare_insert_ctrl_q <= reg_wdata_in;
                default: begin
                    if (reg_addr_in >= `ESB_OFS_TX_SA4 &&
                        reg_addr_in <= `ESB_OFS_TX_SA8) begin
                        tx_spare_bits_q[tx_spare_idx[2:0]] <= reg_wdata_in;
                    end
                end
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        case (reg_addr_in)
            `ESB_OFS_TX_SI_ALIGN: reg_rdata_out = tx_intl_align_bits_q;
            `ESB_OFS_TX_SI_NONALIGN: reg_rdata_out = tx_intl_nonalign_bits_q;
            `ESB_OFS_TX_RALARM: reg_rdata_out = tx_remote_alarm_bits_q;
            `ESB_OFS_TX_SA4: reg_rdata_out = tx_spare_bits_q[0];
            `ESB_OFS_TX_SA5: reg_rdata_out = tx_spare_bits_q[1];
            `ESB_OFS_TX_SA6: reg_rdata_out = tx_spare_bits_q[2];
            `ESB_OFS_TX_SA7: reg_rdata_out = tx_spare_bits_q[3];
            `ESB_OFS_TX_SA8: reg_rdata_out = tx_spare_bits_q[4];
            `ESB_OFS_TX_CTRL: reg_rdata_out = tx_spare_insert_ctrl_q;
            `ESB_OFS_RX_SA6: reg_rdata_out = rx_spare_bits_q[0];
            `ESB_OFS_RX_SA7: reg_rdata_out = rx_spare_bits_q[1];
            `ESB_OFS_RX_SA8: reg_rdata_out = rx_spare_bits_q[2];
            default: reg_rdata_out = 8'h00;
        endcase
    end

    // ********************************
    // receive capture
    // ********************************
    esb_pkg::esb_byte_t rx_shadow_q [3];
    logic rx_last;
    logic rx_odd;
    assign rx_odd = rx_frame_num_in[0];
    assign rx_last = rx_frame_strobe_in && (rx_frame_num_in == 4'hf);

    // RULE_01 RULE_02 RULE_03 collect odd frames
    // RULE_16 first frame lands in msb
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < 3; i++) begin
                rx_shadow_q[i] <= 8'h00;
            end
        end else if (rx_frame_strobe_in && rx_odd) begin
            for (int i = 0; i < 3; i++) begin
                rx_shadow_q[i][esb_pos(rx_frame_num_in)] <= rx_spare_in[i + 2];
            end
        end
    end

    // RULE_13 refresh once per multiframe, frame 15 joined in directly
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < 3; i++) begin
                rx_spare_bits_q[i] <= `ESB_REG_RESET;
            end
        end else if (rx_last) begin
            for (int i = 0; i < 3; i++) begin
                rx_spare_bits_q[i] <= {rx_shadow_q[i][7:1], rx_spare_in[i + 2]};
            end
        end
    end

    // RULE_14 boundary flag, one cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_multiframe_flag_out <= 1'b0;
        end else begin
            rx_multiframe_flag_out <= rx_last;
        end
    end

    // ********************************
    // transmit insertion
    // ********************************
    // working copies, so host writes mid multiframe do not tear a message
    esb_pkg::esb_byte_t tx_work_q [8];
    esb_pkg::esb_byte_t tx_work_ctrl_q;
    logic tx_first;
    assign tx_first = tx_frame_strobe_in && (tx_frame_num_in == 4'h0);

    // RULE_15 sample at the start of each multiframe
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_work_ctrl_q <= `ESB_REG_RESET;
            for (int i = 0; i < 8; i++) begin
                tx_work_q[i] <= `ESB_REG_RESET;
            end
        end else if (tx_first) begin
            tx_work_ctrl_q <= tx_spare_insert_ctrl_q;
            tx_work_q[0] <= tx_intl_align_bits_q;
            tx_work_q[1] <= tx_intl_nonalign_bits_q;
            tx_work_q[2] <= tx_remote_alarm_bits_q;
            for (int i = 0; i < 5; i++) begin
                tx_work_q[i + 3] <= tx_spare_bits_q[i];
            end
        end
    end

    // RULE_15 flag marks the sample instant
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_multiframe_flag_out <= 1'b0;
        end else begin
            tx_multiframe_flag_out <= tx_first;
        end
    end

    // the sample of frame 0 only lands next cycle, so frame 0 uses live regs
    logic [2:0] tx_pos;
    logic tx_odd;
    esb_pkg::esb_byte_t tx_ctrl;
    esb_pkg::esb_byte_t tx_b [8];
    assign tx_pos = esb_pos(tx_frame_num_in);
    assign tx_odd = tx_frame_num_in[0];
    always_comb begin
        tx_ctrl = tx_first ? tx_spare_insert_ctrl_q : tx_work_ctrl_q;
        tx_b[0] = tx_first ? tx_intl_align_bits_q : tx_work_q[0];
        for (int i = 1; i < 8; i++) begin
            tx_b[i] = tx_work_q[i];
        end
    end

    // RULE_11 RULE_10 si select per frame parity
    // RULE_09 RULE_08 remote alarm and spare select
    // RULE_17 default source when disabled
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_si_out <= 1'b0;
            tx_ra_out <= 1'b0;
            tx_spare_out <= 5'h00;
        end else if (tx_frame_strobe_in) begin
            if (!tx_odd) begin
                tx_si_out <= tx_ctrl[`ESB_CTRL_INTL_ALIGN_INSERT_EN] ? tx_b[0][tx_pos]
                                                     : tx_si_dflt_in;
                tx_ra_out <= tx_ra_dflt_in;
                tx_spare_out <= tx_spare_dflt_in;
            end else begin
                tx_si_out <= tx_ctrl[`ESB_CTRL_INTL_NONALIGN_INSERT_EN] ? tx_b[1][tx_pos]
                                                      : tx_si_dflt_in;
                tx_ra_out <= tx_ctrl[`ESB_CTRL_RA] ? tx_b[2][tx_pos]
                                                   : tx_ra_dflt_in;
                for (int i = 0; i < 5; i++) begin
                    tx_spare_out[i] <= tx_ctrl[`ESB_CTRL_SA4 - i] ?
                        tx_b[i + 3][tx_pos] : tx_spare_dflt_in[i];
                end
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    sequence s_rx_end;
        rx_frame_strobe_in && rx_frame_num_in == 4'hf;
    endsequence
    property p_rx_flag;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        s_rx_end |=> rx_multiframe_flag_out;
    endproperty
    a_rx_flag: assert property (p_rx_flag) // RULE_14
        else $error("rx multiframe flag missing");
    property p_rx_sa8_lsb;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        s_rx_end |=> rx_spare_bits_q[2][0] == $past(rx_spare_in[4]);
    endproperty
    a_rx_sa8_lsb: assert property (p_rx_sa8_lsb) // RULE_03
        else $error("sa8 frame 15 not in bit 0");
    property p_rx_stable;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        !rx_last |=> $stable(rx_spare_bits_q[0]);
    endproperty
    a_rx_stable: assert property (p_rx_stable) // RULE_13
        else $error("capture changed off boundary");
    property p_tx_flag;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        tx_first |=> tx_multiframe_flag_out ##1 !tx_multiframe_flag_out;
    endproperty
    a_tx_flag: assert property (p_tx_flag) // RULE_15
        else $error("tx multiframe flag wrong");
    property p_intl_align_insert_en;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        tx_frame_strobe_in && !tx_odd && tx_ctrl[7] |=>
            tx_si_out == $past(tx_b[0][tx_pos]);
    endproperty
    a_intl_align_insert_en: assert property (p_intl_align_insert_en) // RULE_11
        else $error("align si not inserted");
    property p_intl_nonalign_insert_en_off;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        tx_frame_strobe_in && tx_odd && !tx_ctrl[6] |=>
            tx_si_out == $past(tx_si_dflt_in);
    endproperty
    a_intl_nonalign_insert_en_off: assert property (p_intl_nonalign_insert_en_off) // RULE_17
        else $error("non-align si default lost");
    property p_ra;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        tx_frame_strobe_in && tx_odd && tx_ctrl[5] |=>
            tx_ra_out == $past(tx_b[2][tx_pos]);
    endproperty
    a_ra: assert property (p_ra) // RULE_09
        else $error("remote alarm not inserted");
    property p_sa8;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        tx_frame_strobe_in && tx_odd && tx_ctrl[0] |=>
            tx_spare_out[4] == $past(tx_b[7][tx_pos]);
    endproperty
    a_sa8: assert property (p_sa8) // RULE_08
        else $error("sa8 not inserted");
    property p_first_msb;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        tx_frame_strobe_in && tx_frame_num_in == 4'h1 &&
            tx_ctrl[`ESB_CTRL_INTL_NONALIGN_INSERT_EN] |=> tx_si_out == $past(tx_b[1][7]);
    endproperty
    a_first_msb: assert property (p_first_msb) // RULE_16
        else $error("frame 1 not at msb");
    // RULE_16 frame 1 reference, kept apart from the shadow bytes
    logic rx_f1_sa6_q;
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_f1_sa6_q <= 1'b0;
        end else if (rx_frame_strobe_in && rx_frame_num_in == 4'h1) begin
            rx_f1_sa6_q <= rx_spare_in[2];
        end
    end
    property p_rx_msb;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        s_rx_end |=> rx_spare_bits_q[0][7] == rx_f1_sa6_q;
    endproperty
    a_rx_msb: assert property (p_rx_msb) // RULE_16
        else $error("sa6 frame 1 not in bit 7");
    property p_ra_even;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        tx_frame_strobe_in && !tx_odd |=>
            tx_ra_out == $past(tx_ra_dflt_in);
    endproperty
    a_ra_even: assert property (p_ra_even) // RULE_17
        else $error("remote alarm inserted in align frame");
    property p_sa4_off;
        @(posedge ref_clk_in) disable iff (!rst_n_q)
        tx_frame_strobe_in && tx_odd && !tx_ctrl[`ESB_CTRL_SA4] |=>
            tx_spare_out[0] == $past(tx_spare_dflt_in[0]);
    endproperty
    a_sa4_off: assert property (p_sa4_off) // RULE_08
        else $error("sa4 inserted while disabled");
endmodule

//--- esb_far_end.sv
`timescale 1ns/10ps
// ****************************************
// far-end framer: frame timing and capture
// ****************************************
module esb_far_end (
    input wire logic clk_in,
    output logic rx_stb_out,
    output logic [3:0] rx_num_out,
    output logic [4:0] rx_sp_out,
    output logic tx_stb_out,
    output logic [3:0] tx_num_out,
    output logic tx_si_d_out,
    output logic tx_ra_d_out,
    output logic [4:0] tx_sp_d_out,
    input wire logic rx_mf_in,
    input wire logic tx_mf_in,
    input wire logic tx_si_in,
    input wire logic tx_ra_in,
    input wire logic [4:0] tx_sp_in
);
    logic [7:0] got_si_a, got_si_n, got_ra;
    logic [7:0] got_sp [5];
    int rx_mf_n, tx_mf_n;
    // defaults stay fixed so a disabled field reads as a known byte
    initial begin
        rx_stb_out = 1'b0;
        tx_stb_out = 1'b0;
        rx_num_out = 4'h0;
        tx_num_out = 4'h0;
        rx_sp_out = 5'h00;
        tx_si_d_out = 1'b1;
        tx_ra_d_out = 1'b1;
        tx_sp_d_out = 5'h15;
    end
    // one multiframe each way, strobes two cycles apart
    task automatic run_mf(input logic [7:0] s6, s7, s8);
        int b;
        rx_mf_n = 0;
        tx_mf_n = 0;
        for (int f = 0; f < 16; f++) begin
            b = 7 - f / 2;
            @(posedge clk_in);
            #1;
            rx_stb_out = 1'b1;
            tx_stb_out = 1'b1;
            rx_num_out = 4'(f);
            tx_num_out = 4'(f);
            // even frames carry junk that must not be captured
            rx_sp_out = {s8[b], s7[b], s6[b], 2'b01} ^ {5{~f[0]}};
            @(posedge clk_in);
            #1;
            rx_stb_out = 1'b0;
            tx_stb_out = 1'b0;
            rx_sp_out = ~rx_sp_out; // not valid outside strobe
            if (f[0]) begin
                got_si_n[b] = tx_si_in;
                got_ra[b] = tx_ra_in;
                for (int k = 0; k < 5; k++) begin
                    got_sp[k][b] = tx_sp_in[k];
                end
            end else begin
                got_si_a[b] = tx_si_in;
            end
            rx_mf_n += int'(rx_mf_in);
            tx_mf_n += int'(tx_mf_in);
        end
    endtask
endmodule

//--- tb.sv
`timescale 1ns/10ps
`include "esb_consts.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    logic ref_clk_in, reset_n_in, reg_wr_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic rx_stb, tx_stb, si_d, ra_d, rx_mf, tx_mf, si_o, ra_o;
    logic [3:0] rx_num, tx_num;
    logic [4:0] rx_sp, sp_d, sp_o;
    logic [7:0] c;
    int n_fail = 0;
    int cmp_count = 0;
    esb_spare_bits dut_u (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .rx_frame_strobe_in(rx_stb), .rx_frame_num_in(rx_num),
        .rx_spare_in(rx_sp), .rx_multiframe_flag_out(rx_mf),
        .tx_frame_strobe_in(tx_stb), .tx_frame_num_in(tx_num),
        .tx_si_dflt_in(si_d), .tx_ra_dflt_in(ra_d),
        .tx_spare_dflt_in(sp_d), .tx_multiframe_flag_out(tx_mf),
        .tx_si_out(si_o), .tx_ra_out(ra_o), .tx_spare_out(sp_o));
    esb_far_end far_u (.clk_in(ref_clk_in), .rx_stb_out(rx_stb),
        .rx_num_out(rx_num), .rx_sp_out(rx_sp), .tx_stb_out(tx_stb),
        .tx_num_out(tx_num), .tx_si_d_out(si_d), .tx_ra_d_out(ra_d),
        .tx_sp_d_out(sp_d), .rx_mf_in(rx_mf), .tx_mf_in(tx_mf),
        .tx_si_in(si_o), .tx_ra_in(ra_o), .tx_sp_in(sp_o));
    // ****************************************
    // clock, bus cycles, closing
    // ****************************************
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    // distinct byte per transmit register, never 00 or ff
    function automatic logic [7:0] tv(input int k);
        return 8'(8'h5a ^ (k * 8'h13));
    endfunction
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk_in);
        #1;
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e, input string n);
        @(posedge ref_clk_in);
        #1;
        reg_addr_in = a;
        #5;
        `CHK(n, e, reg_rdata_out)
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        for (int a = 8'h42; a <= 8'h4a; a++) rd(8'(a), 8'h00, "rst");
        rd(`ESB_OFS_RX_SA6, 8'h00, "rst_rx");
        rd(8'h50, 8'h00, "unmapped");
    endtask
    task automatic t_regs;
        for (int k = 0; k < 9; k++) wr(8'(8'h42 + k), tv(k));
        for (int k = 0; k < 9; k++) rd(8'(8'h42 + k), tv(k), "rw");
        wr(`ESB_OFS_RX_SA8, 8'hff);
        rd(`ESB_OFS_RX_SA8, 8'h00, "ro");
    endtask
    task automatic t_rx(input logic [7:0] a, b, d);
        far_u.run_mf(a, b, d);
        rd(`ESB_OFS_RX_SA6, a, "sa6");
        rd(`ESB_OFS_RX_SA7, b, "sa7");
        rd(`ESB_OFS_RX_SA8, d, "sa8");
        `CHK("rxmf", 1, far_u.rx_mf_n)
    endtask
    // one enable cleared per pass, last pass all set
    task automatic t_tx;
        for (int i = 0; i < 9; i++) begin
            c = 8'(~(9'h1 << i));
            wr(`ESB_OFS_TX_CTRL, c);
            far_u.run_mf(8'h00, 8'h00, 8'h00);
            `CHK("si_a", c[7] ? tv(0) : 8'hff, far_u.got_si_a)
            `CHK("si_n", c[6] ? tv(1) : 8'hff, far_u.got_si_n)
            `CHK("ra", c[5] ? tv(2) : 8'hff, far_u.got_ra)
            for (int k = 0; k < 5; k++) begin
                `CHK("sa", c[4-k] ? tv(3+k) : {8{sp_d[k]}}, far_u.got_sp[k])
            end
            `CHK("txmf", 1, far_u.tx_mf_n)
        end
    endtask
    // a write mid-multiframe waits for the next one
    task automatic t_sample;
        fork
            far_u.run_mf(8'h00, 8'h00, 8'h00);
            begin
                repeat (6) @(posedge ref_clk_in);
                wr(`ESB_OFS_TX_SA4, 8'hc3);
            end
        join
        `CHK("old", tv(3), far_u.got_sp[0])
        far_u.run_mf(8'h00, 8'h00, 8'h00);
        `CHK("new", 8'hc3, far_u.got_sp[0])
    endtask
    initial begin
        #2000000;
        n_fail++;
        finish_test();
    end
    initial begin
        reset_n_in = 1'b0;
        reg_wr_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        repeat (8) @(posedge ref_clk_in);
        #1;
        reset_n_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        t_reset();
        t_regs();
        t_rx(8'h96, 8'h3c, 8'he1);
        t_rx(8'h01, 8'h80, 8'h5a);
        t_tx();
        t_sample();
        finish_test();
    end
endmodule
